// >>> hw/fdp_bus_if.sv
// Bus interface joining the data-driving end and the data-receiving end.
// Assumes the bench resolves wired levels; data, strobe and power lines carry an enable.
`timescale 1ns/10ps
interface fdp_bus_if;
    import fdp_pkg::*;
    logic [DATA_W-1:0] data_n_o;        // Data lines driven by the sender, active low
    logic              data_oe;         // Data line enable
    logic [GROUPS-1:0] group_invert_n;  // Per-group inversion, active low
    logic [GROUPS-1:0] strobe_pos_n;    // Positive strobes
    logic [GROUPS-1:0] strobe_neg_n;    // Negative strobes
    logic              strobe_oe;       // Strobe enable
    logic              data_valid_n;    // Valid-data qualifier
    logic              data_bus_in_use_n; // Data bus busy
    logic              dbuf_rx_pwr_n;   // Power-reduction level driven by receiver end
    logic              dbuf_rx_pwr_oe;  // Its enable
    logic              dbuf_tx_pwr_n;   // Power-reduction level driven by processor end
    logic              dbuf_tx_pwr_oe;  // Its enable

    modport sender (
        output data_n_o, data_oe, group_invert_n, strobe_pos_n, strobe_neg_n, strobe_oe,
        output data_valid_n, data_bus_in_use_n, dbuf_tx_pwr_n, dbuf_tx_pwr_oe,
        input  dbuf_rx_pwr_n, dbuf_rx_pwr_oe
    );
    modport receiver (
        input  data_n_o, data_oe, group_invert_n, strobe_pos_n, strobe_neg_n, strobe_oe,
        input  data_valid_n, data_bus_in_use_n, dbuf_tx_pwr_n, dbuf_tx_pwr_oe,
        output dbuf_rx_pwr_n, dbuf_rx_pwr_oe
    );
endinterface

// >>> hw/fdp_pkg.sv
// Package for the front-side bus data-phase link: widths, timing counts, states.
// Assumes both ends and the bus interface import it; no other dependency.
package fdp_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W      = 64;
    localparam int GROUP_W     = 16;
    localparam int GROUPS      = 4;
    localparam int BEATS       = 4;

    // ------------------------------------------------------------
    // Timing: the sender divides its clock to make the strobes
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int BEAT_NS        = 40;
    localparam int BEAT_CYCLES    = BEAT_NS / CLK_PERIOD_NS;
    localparam int HALF_BEAT      = BEAT_CYCLES / 2;
    localparam int FIFO_DEPTH     = 32;

    // ------------------------------------------------------------
    // Reset values of the active-low pins
    // ------------------------------------------------------------
    localparam logic [GROUPS-1:0] STROBE_IDLE = 4'hf;
    localparam logic [DATA_W-1:0] DATA_IDLE   = 64'hffffffffffffffff;

    // Sender states
    typedef enum logic [2:0] {
        FDP_IDLE  = 3'b000,
        FDP_BUSY  = 3'b001,
        FDP_BEAT  = 3'b010,
        FDP_GAP   = 3'b011,
        FDP_DONE  = 3'b100
    } fdp_tx_state_t;

endpackage

// >>> hw/fdp_receiver.sv
// Data-receiving end (chipset side): synchronises strobes, latches beats
// on falling edges, undoes inversion, delivers words on data_valid_n low.
// Assumes strobe beats last at least four local clocks.
`timescale 1ns/10ps
module fdp_receiver (
    input  wire logic                        clock,       // 100 MHz clock
    input  wire logic                        reset,       // Synchronous reset
    input  wire logic                        clk_en,      // Freezes state when low
    input  wire logic                        expect_data, // Data may arrive soon
    input  wire logic                        freq_switch, // Bus frequency switch underway
    output logic [fdp_pkg::DATA_W-1:0]       rd_data,     // Received word
    output logic                             rd_valid,    // One-cycle word strobe
    fdp_bus_if.receiver                      bus          // Data-phase pins
);
    import fdp_pkg::*;

    localparam int SW = DATA_W + 3*GROUPS + 2;

    // ------------------------------------------------------------
    // Two-flop synchroniser on the data, inversion, strobe, valid and busy pins
    // ------------------------------------------------------------
    logic [SW-1:0] meta_reg, sync_reg, prev_reg;
    logic [DATA_W-1:0] s_data;
    logic [GROUPS-1:0] s_inv, s_stp, s_stn, p_stp, p_stn, fall_p, fall_n;
    logic              s_valid, s_busy, p_busy;

    always_ff @(posedge clock) begin
        if (reset) begin
            meta_reg <= '1;
            sync_reg <= '1;
            prev_reg <= '1;
        end else if (clk_en) begin
            meta_reg <= {bus.data_n_o, bus.group_invert_n, bus.strobe_pos_n, bus.strobe_neg_n,
                         bus.data_valid_n, bus.data_bus_in_use_n};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    always_comb begin
        {s_data, s_inv, s_stp, s_stn, s_valid, s_busy} = sync_reg;
        // Field order follows the capture concatenation: stp above stn above valid, busy
        p_stp  = prev_reg[GROUPS+2 +: GROUPS];
        p_stn  = prev_reg[2 +: GROUPS];
        p_busy = prev_reg[0];
        fall_p = p_stp & ~s_stp;
        fall_n = p_stn & ~s_stn;
    end

    // ------------------------------------------------------------
    // Beat assembly per group
    // ------------------------------------------------------------
    logic [DATA_W-1:0] acc_reg [BEATS];
    logic [DATA_W-1:0] acc_next [BEATS];
    logic [1:0]        beat_reg, beat_next;
    logic [DATA_W-1:0] out_reg, out_next;
    logic              full_reg, full_next, ov_reg, ov_next;
    logic              any_fall;

    always_comb begin
        any_fall  = |(fall_p | fall_n);
        beat_next = beat_reg;
        full_next = full_reg;
        out_next  = out_reg;
        ov_next   = 1'b0;
        for (int b = 0; b < BEATS; b++) acc_next[b] = acc_reg[b];
        if (s_busy && !p_busy) begin
            beat_next = '0;
            full_next = 1'b0;
        end else if (any_fall) begin
            // Every group latches its 16 bits, inversion undone, into slice g of entry beat_reg
            for (int g = 0; g < GROUPS; g++) begin
                // Pins are active low, so a group sent plain still needs one flip
                acc_next[beat_reg][g*GROUP_W +: GROUP_W] =
                    s_inv[g] ? ~s_data[g*GROUP_W +: GROUP_W] : s_data[g*GROUP_W +: GROUP_W];
            end
            beat_next = beat_reg + 2'd1;
            full_next = (beat_reg == 2'd3);
        end
        if (full_reg && !s_valid) begin
            // Only a clock with the qualifier low delivers the word
            for (int g = 0; g < GROUPS; g++) begin
                for (int b = 0; b < BEATS; b++) begin
                    out_next[g*GROUP_W + b*(GROUP_W/BEATS) +: GROUP_W/BEATS] = '0;
                end
            end
            for (int b = 0; b < BEATS; b++) out_next[b*GROUP_W +: GROUP_W] = acc_reg[b][b*GROUP_W +: GROUP_W];
            full_next = 1'b0;
            ov_next   = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            for (int b = 0; b < BEATS; b++) acc_reg[b] <= '0;
            beat_reg <= '0;
            full_reg <= 1'b0;
            out_reg  <= '0;
            ov_reg   <= 1'b0;
        end else if (clk_en) begin
            for (int b = 0; b < BEATS; b++) acc_reg[b] <= acc_next[b];
            beat_reg <= beat_next;
            full_reg <= full_next;
            out_reg  <= out_next;
            ov_reg   <= ov_next;
        end
    end

    // Power-reduction: asserted when idle with no data expected, released during a switch
    always_comb begin
        rd_data            = out_reg;
        rd_valid           = ov_reg;
        bus.dbuf_rx_pwr_n  = expect_data | ~s_busy;
        bus.dbuf_rx_pwr_oe = ~freq_switch;
    end
endmodule

// >>> hw/fdp_sender.sv
// Data-driving end (processor side): FIFO of 64-bit words, bus inversion,
// source-synchronous strobes made by dividing the local clock.
// Assumes the receiver end samples the data, inversion, strobe, valid and busy pins through two flip-flops.
`timescale 1ns/10ps

// ------------------------------------------------------------
// Word FIFO
// ------------------------------------------------------------
module fdp_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 32
) (
    input  wire logic             clock,    // System clock
    input  wire logic             reset,    // Synchronous reset
    input  wire logic             clk_en,   // Freezes state when low
    input  wire logic [WIDTH-1:0] in_data,  // Write word
    input  wire logic             in_valid, // Write request
    output logic                  in_ready, // Not full
    output logic [WIDTH-1:0]      out_data, // Head word
    output logic                  out_valid,// Not empty
    input  wire logic             out_ready // Pop
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fdp_fifo: DEPTH must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;

    // Pointers compare on the wrap bit for honest full and empty
    always_comb begin
        in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
        out_valid = wr_reg != rd_reg;
        out_data  = mem[rd_reg[AW-1:0]];
        wr_next   = wr_reg + (AW+1)'(in_valid && in_ready);
        rd_next   = rd_reg + (AW+1)'(out_valid && out_ready);
    end

    // Storage and pointers
    always_ff @(posedge clock) begin
        if (reset) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else if (clk_en) begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            if (in_valid && in_ready) begin
                mem[wr_reg[AW-1:0]] <= in_data;
            end
        end
    end
endmodule

// ------------------------------------------------------------
// Sender end
// ------------------------------------------------------------
module fdp_sender #(
    parameter int BEAT_CYC = fdp_pkg::BEAT_CYCLES,
    parameter int IDLE_GAP = 0
) (
    input  wire logic                        clock,      // 100 MHz clock
    input  wire logic                        reset,      // Synchronous reset
    input  wire logic                        clk_en,     // Freezes state when low
    input  wire logic [fdp_pkg::DATA_W-1:0]  wr_data,    // Word to send
    input  wire logic                        wr_valid,   // Word offered
    output logic                             wr_ready,   // FIFO has room
    input  wire logic                        freq_switch,// Bus frequency switch underway
    output logic                             sending,    // Bus owned
    fdp_bus_if.sender                        bus         // Data-phase pins
);
    import fdp_pkg::*;

    initial begin
        if (BEAT_CYC < 2 || BEAT_CYC % 2 != 0) $error("fdp_sender: BEAT_CYC must be even and >= 2");
        if (BEAT_CYC > 256) $error("fdp_sender: BEAT_CYC exceeds the 8-bit cycle counter");
        if (IDLE_GAP < 0 || IDLE_GAP > 255) $error("fdp_sender: IDLE_GAP out of range");
    end

    localparam int HB = BEAT_CYC / 2;

    logic [DATA_W-1:0] f_data;
    logic              f_valid;
    logic              f_pop;

    fdp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock     (clock),
        .reset     (reset),
        .clk_en    (clk_en),
        .in_data   (wr_data),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (f_pop)
    );

    fdp_tx_state_t     state_reg, state_next;
    logic [7:0]        cnt_reg, cnt_next;
    logic [1:0]        beat_reg, beat_next;
    logic [DATA_W-1:0] word_reg, word_next;
    logic [DATA_W-1:0] pins_reg, pins_next;
    logic [GROUPS-1:0] inv_reg, inv_next;
    logic [GROUPS-1:0] stp_reg, stp_next, stn_reg, stn_next;
    logic              valid_reg, valid_next, busy_reg, busy_next;
    logic [GROUP_W-1:0] slice;
    logic [GROUPS-1:0] inv_calc;
    logic [DATA_W-1:0] enc_calc;

    // Bus inversion per group: compare next slice with what is on the pins
    always_comb begin
        slice = word_reg[beat_reg*GROUP_W +: GROUP_W];
        for (int g = 0; g < GROUPS; g++) begin
            inv_calc[g] = $countones(slice ^ ~pins_reg[g*GROUP_W +: GROUP_W]) > GROUP_W/2;
            enc_calc[g*GROUP_W +: GROUP_W] = inv_calc[g] ? ~slice : slice;
        end
    end

    // Transfer sequencer; one word is four 16-bit beats on each group
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        beat_next  = beat_reg;
        word_next  = word_reg;
        pins_next  = pins_reg;
        inv_next   = inv_reg;
        stp_next   = stp_reg;
        stn_next   = stn_reg;
        valid_next = valid_reg;
        busy_next  = busy_reg;
        f_pop      = 1'b0;
        case (state_reg)
            FDP_IDLE: begin
                if (f_valid) begin
                    word_next  = f_data;
                    f_pop      = 1'b1;
                    busy_next  = 1'b0;
                    beat_next  = 2'd0;
                    cnt_next   = '0;
                    state_next = FDP_BUSY;
                end
            end
            FDP_BUSY: begin
                // Data and inversion put out, strobes still high
                pins_next  = ~enc_calc;
                inv_next   = ~inv_calc;
                valid_next = 1'b0;
                cnt_next   = '0;
                state_next = FDP_BEAT;
            end
            FDP_BEAT: begin
                cnt_next = cnt_reg + 8'd1;
                if (cnt_reg == 8'(HB - 1)) begin
                    // Falling edge latches the beat; pos for even beats, neg for odd
                    if (beat_reg[0]) stn_next = '0;
                    else stp_next = '0;
                end
                if (cnt_reg == 8'(BEAT_CYC - 1)) begin
                    stp_next = '1;
                    stn_next = '1;
                    cnt_next = '0;
                    if (beat_reg == 2'd3) begin
                        valid_next = 1'b1;
                        state_next = (IDLE_GAP > 0) ? FDP_GAP : FDP_DONE;
                    end else begin
                        beat_next  = beat_reg + 2'd1;
                        state_next = FDP_BUSY;
                    end
                end
            end
            FDP_GAP: begin
                // Idle clocks with valid dropped, bus still held
                cnt_next = cnt_reg + 8'd1;
                if (cnt_reg == 8'(IDLE_GAP - 1)) state_next = FDP_DONE;
            end
            FDP_DONE: begin
                if (f_valid) begin
                    word_next  = f_data;
                    f_pop      = 1'b1;
                    beat_next  = 2'd0;
                    state_next = FDP_BUSY;
                end else begin
                    busy_next  = 1'b1;
                    state_next = FDP_IDLE;
                end
            end
            default: state_next = FDP_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= FDP_IDLE;
            cnt_reg   <= '0;
            beat_reg  <= '0;
            word_reg  <= '0;
            pins_reg  <= DATA_IDLE;
            inv_reg   <= STROBE_IDLE;
            stp_reg   <= STROBE_IDLE;
            stn_reg   <= STROBE_IDLE;
            valid_reg <= 1'b1;
            busy_reg  <= 1'b1;
        end else if (clk_en) begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            beat_reg  <= beat_next;
            word_reg  <= word_next;
            pins_reg  <= pins_next;
            inv_reg   <= inv_next;
            stp_reg   <= stp_next;
            stn_reg   <= stn_next;
            valid_reg <= valid_next;
            busy_reg  <= busy_next;
        end
    end

    // Pins; drivers stay enabled while busy so the receiver sees clean levels
    always_comb begin
        sending               = ~busy_reg;
        bus.data_n_o          = pins_reg;
        bus.group_invert_n    = inv_reg;
        bus.strobe_pos_n      = stp_reg;
        bus.strobe_neg_n      = stn_reg;
        bus.data_oe           = ~busy_reg;
        bus.strobe_oe         = ~busy_reg;
        bus.data_valid_n      = valid_reg;
        bus.data_bus_in_use_n = busy_reg;
        bus.dbuf_tx_pwr_n     = 1'b1;
        bus.dbuf_tx_pwr_oe    = freq_switch;
    end
endmodule

// >>> verification/fdp_link_properties.sv
// Checker for the data-phase link between the sender and receiver ends.
// Assumes the bench instantiates it beside the bus interface, same clock.
`timescale 1ns/10ps
module fdp_link_properties (
    input wire logic                       clock,             // System clock
    input wire logic                       reset,             // Synchronous reset
    input wire logic                       freq_switch,       // Frequency switch underway
    input wire logic [fdp_pkg::DATA_W-1:0] data_n_o,          // Data pins
    input wire logic                       data_oe,           // Data enable
    input wire logic [fdp_pkg::GROUPS-1:0] group_invert_n,    // Inversion pins
    input wire logic [fdp_pkg::GROUPS-1:0] strobe_pos_n,      // Positive strobes
    input wire logic [fdp_pkg::GROUPS-1:0] strobe_neg_n,      // Negative strobes
    input wire logic                       strobe_oe,         // Strobe enable
    input wire logic                       data_valid_n,      // Valid qualifier
    input wire logic                       data_bus_in_use_n, // Bus busy
    input wire logic                       dbuf_rx_pwr_oe,    // Receiver power enable
    input wire logic                       dbuf_tx_pwr_oe     // Sender power enable
);
    import fdp_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // No group may toggle more than half its lines between beats
    function automatic bit dbi_ok(logic [DATA_W-1:0] a, logic [DATA_W-1:0] b);
        int g;
        dbi_ok = 1'b1;
        for (g = 0; g < GROUPS; g++) begin
            if ($countones(a[g*GROUP_W +: GROUP_W] ^ b[g*GROUP_W +: GROUP_W]) > GROUP_W / 2) begin
                dbi_ok = 1'b0;
            end
        end
    endfunction

    // Strobe stays low two cycles while its partner stays high
    sequence s_low_two(s, o);
        (!s && o) [*2];
    endsequence
    sequence s_word_end;
        data_valid_n ##[1:40] !data_valid_n;
    endsequence
    sequence s_valid_held;
        (!data_valid_n) [*8];
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_valid_in_busy: assert property (!data_valid_n |-> !data_bus_in_use_n)
        else $error("valid qualifier outside busy");
    a_busy_then_valid: assert property ($fell(data_bus_in_use_n) |-> s_word_end)
        else $error("word without valid qualifier");
    a_valid_spans_beats: assert property ($fell(data_valid_n) |-> s_valid_held)
        else $error("valid qualifier dropped inside a word");
    a_valid_under_strobe: assert property (!(strobe_pos_n[0] && strobe_neg_n[0]) |-> !data_valid_n)
        else $error("strobe pulse without valid qualifier");
    a_inversion_limit: assert property (data_oe && $past(data_oe) |-> dbi_ok(data_n_o, $past(data_n_o)))
        else $error("group toggles more than half its lines");
    a_pos_strobe_pulse: assert property ($fell(strobe_pos_n[0]) |-> s_low_two(strobe_pos_n[0], strobe_neg_n[0]) ##1 strobe_pos_n[0])
        else $error("positive strobe pulse wrong");
    a_neg_strobe_pulse: assert property ($fell(strobe_neg_n[0]) |-> s_low_two(strobe_neg_n[0], strobe_pos_n[0]) ##1 strobe_neg_n[0])
        else $error("negative strobe pulse wrong");
    a_groups_together: assert property ((&strobe_pos_n || ~|strobe_pos_n) && (&strobe_neg_n || ~|strobe_neg_n))
        else $error("strobe groups differ");
    a_data_held_strobe: assert property (!(strobe_pos_n[0] && strobe_neg_n[0]) |-> $stable(data_n_o) && $stable(group_invert_n) && strobe_oe && data_oe && !data_bus_in_use_n)
        else $error("data moves under a strobe");
    a_cpu_drives_pwr: assert property (freq_switch [*3] |-> dbuf_tx_pwr_oe && !dbuf_rx_pwr_oe)
        else $error("power line not driven by sender during switch");
    a_chip_drives_pwr: assert property (!freq_switch [*3] |-> dbuf_rx_pwr_oe && !dbuf_tx_pwr_oe)
        else $error("power line not driven by receiver");
endmodule

// >>> verification/testbench.sv
// Self-checking bench: sender feeds receiver across the bus interface.
// Assumes the design files and package are compiled first.
`timescale 1ns/10ps
module testbench;
    import fdp_pkg::*;

    logic                 clock = 1'b0;  // 100 MHz
    logic                 reset = 1'b1;  // Held 8 cycles
    logic                 clk_en = 1'b1; // Always running
    logic [DATA_W-1:0]    wr_data = '0;
    logic                 wr_valid = 1'b0;
    logic                 wr_ready;
    logic                 freq_switch = 1'b0;
    logic                 expect_data = 1'b0;
    logic                 sending;
    logic [DATA_W-1:0]    rd_data;
    logic                 rd_valid;
    logic [DATA_W-1:0]    exp_q[$];
    int                   mismatches = 0;
    int                   tests_run = 0;
    int                   cycles = 0;
    logic                 full_seen;

    fdp_bus_if bus_if ();
    // Two idle clocks after each word so the dropped-qualifier path is exercised
    fdp_sender #(.IDLE_GAP(2)) fdp_sender_inst (.clock(clock), .reset(reset), .clk_en(clk_en), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .freq_switch(freq_switch), .sending(sending), .bus(bus_if));
    fdp_receiver fdp_receiver_inst (.clock(clock), .reset(reset), .clk_en(clk_en), .expect_data(expect_data),
        .freq_switch(freq_switch), .rd_data(rd_data), .rd_valid(rd_valid), .bus(bus_if));
    fdp_link_properties fdp_link_properties_inst (.clock(clock), .reset(reset), .freq_switch(freq_switch),
        .data_n_o(bus_if.data_n_o), .data_oe(bus_if.data_oe), .group_invert_n(bus_if.group_invert_n),
        .strobe_pos_n(bus_if.strobe_pos_n), .strobe_neg_n(bus_if.strobe_neg_n), .strobe_oe(bus_if.strobe_oe),
        .data_valid_n(bus_if.data_valid_n), .data_bus_in_use_n(bus_if.data_bus_in_use_n),
        .dbuf_rx_pwr_oe(bus_if.dbuf_rx_pwr_oe), .dbuf_tx_pwr_oe(bus_if.dbuf_tx_pwr_oe));

    // ------------------------------------------------------------
    // Clock, timeout, comparison
    // ------------------------------------------------------------
    always #5 clock = ~clock;

    // Ceiling well above the roughly 1400 cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("[ERR] %0t ns run did not finish", $time);
            finish_test();
        end
    end

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Oldest note is matched against each delivered word
    always @(posedge clock) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("[ERR] %0t ns unexpected word %h", $time, rd_data);
            end else begin
                check(rd_data, exp_q.pop_front());
            end
        end
    end

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    // Holds the word until accepted; a refused edge adds no note
    task automatic put_word(input logic [DATA_W-1:0] w);
        int n;
        n = 0;
        wr_data  <= w;
        wr_valid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (wr_ready !== 1'b1) full_seen = 1'b1;
        end while (wr_ready !== 1'b1 && n < 2000);
        exp_q.push_back(w);
    endtask

    // Lets the link drain, then checks the released idle levels
    task automatic drain(input string name);
        int n;
        n = 0;
        wr_valid <= 1'b0;
        while (exp_q.size() != 0 && n < 5000) begin
            @(posedge clock);
            n++;
        end
        repeat (10) @(posedge clock);
        check(bus_if.data_bus_in_use_n, 1'b1);
        check(sending, 1'b0);
        check({bus_if.data_valid_n, bus_if.strobe_pos_n, bus_if.strobe_neg_n}, 9'h1ff);
        $display("test %s done", name);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    logic [DATA_W-1:0] corner[6] = '{64'h0, 64'hffffffffffffffff, 64'h5555555555555555,
                                     64'haaaaaaaaaaaaaaaa, 64'h00ff00ff00ff00ff, 64'hffff0000ffff0000};
    initial begin
        void'($urandom(49463));
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        expect_data <= 1'b1;
        put_word({$urandom, $urandom});
        drain("single");
        // Back to back corner words force the inversion both ways
        foreach (corner[i]) put_word(corner[i]);
        for (int i = 0; i < 6; i++) put_word({$urandom, $urandom});
        drain("burst");
        // Overfill so the FIFO refuses, then empty it
        full_seen = 1'b0;
        for (int i = 0; i < 40; i++) put_word({$urandom, $urandom});
        check(full_seen, 1'b1);
        drain("fill");
        check(bus_if.dbuf_rx_pwr_n, 1'b1);
        // Sender owns the power line only while switching
        freq_switch <= 1'b1;
        repeat (4) @(posedge clock);
        check({bus_if.dbuf_tx_pwr_oe, bus_if.dbuf_rx_pwr_oe}, 2'b10);
        put_word(corner[2]);
        put_word({$urandom, $urandom});
        drain("switch");
        freq_switch <= 1'b0;
        expect_data <= 1'b0;
        repeat (4) @(posedge clock);
        check({bus_if.dbuf_tx_pwr_oe, bus_if.dbuf_rx_pwr_oe}, 2'b01);
        check(bus_if.dbuf_rx_pwr_n, 1'b0);
        $display("test power done");
        finish_test();
    end
endmodule
